// ==== rtl/clu_core.sv ====
// Design decision made here: the plain strobed port.
`timescale 1ns/1ns
// Function
// - Latch mode: even output is data, odd is gate; gate high follows.
// - Set-clear latch: even sets, odd clears, both low holds.
// - Without clock select, filter, edge, sequencer run each clk.
// - With clock select, table input 2 rising edges clock filter and edge.
// - Sequencer uses the even table's selected clock.
// - Input 2 reads as zero in lookup while it is the clock.
// - Table outputs leave as events; event lines usable as inputs.
// - Keep-running bit set: clocked logic runs in standby.
// - Bit clear: tables using clocked logic output zero in standby.
// - Idle sleep: plain lookup keeps running.
// - Global control at 0x00: bit 6 keep-running, bit 0 enable.
// - Sequencer field: off, data flop, JK flop, data latch, set-clear.
// - Table control: edge 7, clock select 6, filter 5:4, pin 3, enable 0.
// - Filter field: none, two-stage sync, glitch filter; 3 reserved.
// - Pin drive enable makes table output drive its pin.
// - Input source field codes 0x0 to 0xb; others reserved.
// - Inputs index the truth byte, input 2 most significant.
// - Sync delays two table edges; glitch filter needs three, delays four.
// - Protected fields write only while table disabled.
// - Link input takes the other table's output.
module clu_core (
  input wire logic clk,
  input wire logic reset_n,
  input wire clu_pkg::clu_bus_req_type bus_req,
  output logic [7:0] bus_rdata,
  input wire clu_pkg::clu_src_type src,
  input wire logic [5:0] pin_in,
  input wire logic standby_sleep,
  input wire logic idle_sleep,
  output logic [1:0] table_result_event,
  output logic [1:0] pin_out,
  output logic [1:0] pin_oe
);
  import clu_pkg::*;

  logic glob_en_reg;
  logic run_reg;
  logic [3:0] seq_sel_reg;
  logic [7:0] rdata_reg;
  logic [7:0] rd_val;
  logic [5:0] pin_val_reg;
  logic [1:0][7:0] ctrl_a_w;
  logic [1:0][7:0] ctrl_b_w;
  logic [1:0][7:0] ctrl_c_w;
  logic [1:0][7:0] truth_w;
  logic [1:0][2:0] idx_w;
  logic [1:0][2:0] in_w;
  logic [1:0][3:0] stage_w;
  logic [1:0] lut_w;
  logic [1:0] stage_out_w;
  logic [1:0] tick_w;
  logic [1:0] active_w;
  logic [1:0] uses_w;
  logic [1:0] out_reg;
  logic seq_q_reg;
  logic seq_val;
  logic seq_on;
  logic stall;

  // Standby without keep-running stops the filter, edge and sequencer stages
  assign stall = standby_sleep & ~run_reg;
  assign seq_on = (seq_sel_reg >= CLU_SEQ_DFLOP) && (seq_sel_reg <= CLU_SEQ_SETCLR);

  // Global control, never protected
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      glob_en_reg <= 1'b0;
      run_reg <= 1'b0;
    end else if (bus_req.wr && bus_req.addr == CLU_OFF_CTRL) begin
      glob_en_reg <= bus_req.wdata[CLU_CTRL_EN_BIT];
      run_reg <= bus_req.wdata[CLU_CTRL_RUN_BIT];
    end
  end

  // Sequencer field is protected by both tables of the pair
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      seq_sel_reg <= CLU_SEQ_OFF;
    end else if (bus_req.wr && bus_req.addr == CLU_OFF_SEQ &&
                 !ctrl_a_w[0][CLU_A_EN_BIT] && !ctrl_a_w[1][CLU_A_EN_BIT]) begin
      seq_sel_reg <= bus_req.wdata[3:0];
    end
  end

  // Pin inputs: three flops, a change counts when stages two and three agree
  genvar p;
  generate
    for (p = 0; p < 6; p++) begin : g_pin
      logic s1_reg;
      logic s2_reg;
      logic s3_reg;
      always_ff @(posedge clk) begin
        if (!reset_n) begin
          s1_reg <= 1'b0;
          s2_reg <= 1'b0;
          s3_reg <= 1'b0;
          pin_val_reg[p] <= 1'b0;
        end else begin
          s1_reg <= pin_in[p];
          s2_reg <= s1_reg;
          s3_reg <= s2_reg;
          if (s2_reg == s3_reg) begin
            pin_val_reg[p] <= s3_reg;
          end
        end
      end
    end
  endgenerate

  genvar n;
  genvar k;
  generate
    for (n = 0; n < CLU_TABLES; n++) begin : g_tbl
      localparam logic [3:0] BASE = 4'(CLU_OFF_TBL + n * CLU_TBL_STRIDE);
      logic [7:0] a_reg;
      logic [7:0] b_reg;
      logic [7:0] c_reg;
      logic [7:0] t_reg;
      logic [3:0] st_reg;
      logic filt_q_reg;
      logic in2_prev_reg;
      logic edge_prev_reg;
      logic edge_q_reg;
      logic [1:0] filt;
      logic csrc;
      logic filt_val;
      logic final_val;
      logic wr_ok;

      assign filt = a_reg[CLU_A_FILT_LSB +: 2];
      assign csrc = a_reg[CLU_A_CSRC_BIT];
      assign wr_ok = bus_req.wr && !a_reg[CLU_A_EN_BIT];

      // Enable bit always writable, the rest only while disabled
      always_ff @(posedge clk) begin
        if (!reset_n) begin
          a_reg <= CLU_RESET_VAL;
        end else if (bus_req.wr && bus_req.addr == BASE) begin
          if (!a_reg[CLU_A_EN_BIT]) begin
            a_reg <= bus_req.wdata & CLU_A_MASK;
          end else begin
            a_reg[CLU_A_EN_BIT] <= bus_req.wdata[CLU_A_EN_BIT];
          end
        end
      end

      // Input selects and truth byte
      always_ff @(posedge clk) begin
        if (!reset_n) begin
          b_reg <= CLU_RESET_VAL;
          c_reg <= CLU_RESET_VAL;
          t_reg <= CLU_RESET_VAL;
        end else if (wr_ok) begin
          if (bus_req.addr == BASE + CLU_TBL_B) b_reg <= bus_req.wdata;
          if (bus_req.addr == BASE + CLU_TBL_C) c_reg <= bus_req.wdata & CLU_C_MASK;
          if (bus_req.addr == BASE + CLU_TBL_T) t_reg <= bus_req.wdata;
        end
      end

      // Input multiplexers, reserved codes read as masked
      for (k = 0; k < 3; k++) begin : g_in
        logic [3:0] code;
        assign code = (k == 0) ? b_reg[3:0] :
                      (k == 1) ? b_reg[CLU_B_SRC1_LSB +: 4] : c_reg[3:0];
        always_comb begin
          unique case (code)
            CLU_SRC_FEEDBACK: in_w[n][k] = seq_q_reg;
            CLU_SRC_LINK: in_w[n][k] = out_reg[(n + 1) % CLU_TABLES];
            CLU_SRC_EVLINE0: in_w[n][k] = src.event_line_0;
            CLU_SRC_EVLINE1: in_w[n][k] = src.event_line_1;
            CLU_SRC_PIN: in_w[n][k] = pin_val_reg[3 * n + k];
            CLU_SRC_CMP: in_w[n][k] = src.comparator_output;
            CLU_SRC_CAPT: in_w[n][k] = src.capture_timer_waveform;
            CLU_SRC_MAIN: in_w[n][k] = src.main_timer_waveform[k];
            CLU_SRC_CTRLT: in_w[n][k] = src.control_timer_waveform[k == 1];
            CLU_SRC_UART: in_w[n][k] = (k < 2) ? src.serial_transceiver_line[k % 2] : 1'b0;
            CLU_SRC_SPI: in_w[n][k] = src.serial_peripheral_line[k];
            default: in_w[n][k] = 1'b0;
          endcase
        end
      end

      // Lookup: input 2 is the top index bit, held low while it clocks
      assign active_w[n] = glob_en_reg & a_reg[CLU_A_EN_BIT];
      assign idx_w[n] = {in_w[n][2] & ~csrc, in_w[n][1], in_w[n][0]};
      assign lut_w[n] = active_w[n] & t_reg[idx_w[n]];

      // Table clock: each clk, or rising edges of input 2
      assign tick_w[n] = ~stall & (csrc ? (in_w[n][2] & ~in2_prev_reg) : 1'b1);
      always_ff @(posedge clk) begin
        if (!reset_n) begin
          in2_prev_reg <= 1'b0;
        end else begin
          in2_prev_reg <= in_w[n][2];
        end
      end

      // Filter; a disabled table clears it on the next edge
      always_ff @(posedge clk) begin
        if (!reset_n || !active_w[n]) begin
          st_reg <= 4'h0;
          filt_q_reg <= 1'b0;
        end else if (tick_w[n]) begin
          st_reg <= {st_reg[2:0], lut_w[n]};
          if (filt == CLU_FILT_SYNC) begin
            filt_q_reg <= st_reg[0];
          end else if (st_reg[0] == st_reg[1] && st_reg[1] == st_reg[2]) begin
            filt_q_reg <= st_reg[2];
          end
        end
      end
      assign stage_w[n] = st_reg;
      // Reserved filter code passes the raw lookup
      assign filt_val = (filt == CLU_FILT_SYNC || filt == CLU_FILT_GLITCH) ?
                        filt_q_reg : lut_w[n];

      // Rising edge detector, one table clock wide
      always_ff @(posedge clk) begin
        if (!reset_n || !active_w[n]) begin
          edge_prev_reg <= 1'b0;
          edge_q_reg <= 1'b0;
        end else if (tick_w[n]) begin
          edge_prev_reg <= filt_val;
          edge_q_reg <= filt_val & ~edge_prev_reg;
        end
      end
      assign stage_out_w[n] = a_reg[CLU_A_EDGE_BIT] ? edge_q_reg : filt_val;

      assign uses_w[n] = (filt == CLU_FILT_SYNC) || (filt == CLU_FILT_GLITCH) ||
                         a_reg[CLU_A_EDGE_BIT] || seq_on;
      // Even table carries the sequencer result when one is chosen
      assign final_val = (stall && uses_w[n]) ? 1'b0 :
                         (n == 0 && seq_on) ? seq_val : stage_out_w[n];

      // Registered result feeds events, pin and link paths
      always_ff @(posedge clk) begin
        if (!reset_n) begin
          out_reg[n] <= 1'b0;
        end else begin
          out_reg[n] <= active_w[n] & final_val;
        end
      end

      assign ctrl_a_w[n] = a_reg;
      assign ctrl_b_w[n] = b_reg;
      assign ctrl_c_w[n] = c_reg;
      assign truth_w[n] = t_reg;
    end
  endgenerate

  // Latches are transparent so their result is combinational
  always_comb begin
    unique case (seq_sel_reg)
      CLU_SEQ_LATCH: seq_val = stage_out_w[1] ? stage_out_w[0] : seq_q_reg;
      CLU_SEQ_SETCLR: begin
        if (stage_out_w[0] && !stage_out_w[1]) seq_val = 1'b1;
        else if (!stage_out_w[0] && stage_out_w[1]) seq_val = 1'b0;
        else seq_val = seq_q_reg; // Forbidden pair is held
      end
      CLU_SEQ_DFLOP, CLU_SEQ_TOGGLE: seq_val = seq_q_reg;
      default: seq_val = 1'b0;
    endcase
  end

  // Sequencer state: flops on the even table's clock, latches each clk unless stalled; cleared with the even table
  always_ff @(posedge clk) begin
    if (!reset_n || !active_w[0]) begin
      seq_q_reg <= 1'b0;
    end else begin
      unique case (seq_sel_reg)
        CLU_SEQ_DFLOP: if (tick_w[0] && stage_out_w[1]) seq_q_reg <= stage_out_w[0];
        CLU_SEQ_TOGGLE: begin
          if (tick_w[0]) begin
            unique case ({stage_out_w[0], stage_out_w[1]})
              2'b01: seq_q_reg <= 1'b0;
              2'b10: seq_q_reg <= 1'b1;
              2'b11: seq_q_reg <= ~seq_q_reg;
              default: seq_q_reg <= seq_q_reg;
            endcase
          end
        end
        CLU_SEQ_LATCH, CLU_SEQ_SETCLR: if (!stall) seq_q_reg <= seq_val;
        default: seq_q_reg <= 1'b0;
      endcase
    end
  end

  // Read decode, unmapped and reserved read zero
  always_comb begin
    rd_val = 8'h00;
    if (bus_req.addr == CLU_OFF_CTRL) rd_val = {1'b0, run_reg, 5'h00, glob_en_reg};
    if (bus_req.addr == CLU_OFF_SEQ) rd_val = {4'h0, seq_sel_reg} & CLU_SEQ_MASK;
    for (int i = 0; i < CLU_TABLES; i++) begin
      if (bus_req.addr == 4'(CLU_OFF_TBL + i * CLU_TBL_STRIDE)) rd_val = ctrl_a_w[i];
      if (bus_req.addr == 4'(CLU_OFF_TBL + i * CLU_TBL_STRIDE + CLU_TBL_B)) rd_val = ctrl_b_w[i];
      if (bus_req.addr == 4'(CLU_OFF_TBL + i * CLU_TBL_STRIDE + CLU_TBL_C)) rd_val = ctrl_c_w[i];
      if (bus_req.addr == 4'(CLU_OFF_TBL + i * CLU_TBL_STRIDE + CLU_TBL_T)) rd_val = truth_w[i];
    end
  end

  // Read data stands one cycle only
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      rdata_reg <= 8'h00;
    end else begin
      rdata_reg <= bus_req.rd ? rd_val : 8'h00;
    end
  end

  assign bus_rdata = rdata_reg;
  assign table_result_event = out_reg;
  assign pin_out = out_reg;
  assign pin_oe = {ctrl_a_w[1][CLU_A_PIN_BIT], ctrl_a_w[0][CLU_A_PIN_BIT]};

  // Checks
  sequence latch_open;
    seq_sel_reg == CLU_SEQ_LATCH && active_w[0] && !stall && stage_out_w[1];
  endsequence
  sequence latch_shut;
    seq_sel_reg == CLU_SEQ_LATCH && active_w[0] && !stall && !stage_out_w[1];
  endsequence
  sequence sync_held;
    (active_w[0] && ctrl_a_w[0][5:4] == CLU_FILT_SYNC && !ctrl_a_w[0][CLU_A_CSRC_BIT] &&
     !stall)[*3];
  endsequence

  latch_follow_a: assert property (@(posedge clk) disable iff (!reset_n)
    latch_open |=> out_reg[0] == $past(stage_out_w[0]))
    else $error("latch output does not follow data");
  set_latch_a: assert property (@(posedge clk) disable iff (!reset_n)
    (seq_sel_reg == CLU_SEQ_SETCLR && active_w[0] && !stall && stage_out_w[0] &&
     !stage_out_w[1]) |=> out_reg[0] && seq_q_reg)
    else $error("set-clear latch not set");
  sync_delay_a: assert property (@(posedge clk) disable iff (!reset_n)
    sync_held |-> stage_w[0][1] == $past(lut_w[0], 2))
    else $error("sync stage delay wrong");
  clk_in2_low_a: assert property (@(posedge clk) disable iff (!reset_n)
    ctrl_a_w[0][CLU_A_CSRC_BIT] |-> !idx_w[0][2])
    else $error("clock input seen by lookup");
  standby_zero_a: assert property (@(posedge clk) disable iff (!reset_n)
    (stall && uses_w[0]) |=> !out_reg[0])
    else $error("output not forced low in standby");
  prot_truth_a: assert property (@(posedge clk) disable iff (!reset_n)
    (bus_req.wr && ctrl_a_w[0][CLU_A_EN_BIT] &&
     bus_req.addr == CLU_OFF_TBL + CLU_TBL_T) |=> $stable(truth_w[0]))
    else $error("protected truth byte changed");
  link_path_a: assert property (@(posedge clk) disable iff (!reset_n)
    (ctrl_b_w[1][3:0] == CLU_SRC_LINK) |-> in_w[1][0] == out_reg[0])
    else $error("link input mismatch");
  seq_rsvd_a: assert property (@(posedge clk) disable iff (!reset_n)
    (seq_sel_reg > CLU_SEQ_SETCLR && !stall) |=> out_reg[0] == $past(stage_out_w[0]))
    else $error("reserved sequencer code active");
  idle_plain_a: assert property (@(posedge clk) disable iff (!reset_n)
    (idle_sleep && !uses_w[0]) |=> out_reg[0] == $past(lut_w[0]))
    else $error("lookup stopped in idle");
  pin_drive_a: assert property (@(posedge clk) disable iff (!reset_n)
    pin_oe[0] |-> pin_out[0] == table_result_event[0])
    else $error("pin not driven by table");
  // Closed gate must hold the stored level, not the live data
  latch_hold_a: assert property (@(posedge clk) disable iff (!reset_n)
    latch_shut |=> out_reg[0] == $past(seq_q_reg))
    else $error("latch output moved while gate low");
  clear_latch_a: assert property (@(posedge clk) disable iff (!reset_n)
    (seq_sel_reg == CLU_SEQ_SETCLR && active_w[0] && !stall && !stage_out_w[0] &&
     stage_out_w[1]) |=> !out_reg[0] && !seq_q_reg)
    else $error("set-clear latch not cleared");
  // With input 2 as clock the filter may only move on its rising edges
  csrc_hold_a: assert property (@(posedge clk) disable iff (!reset_n)
    (ctrl_a_w[0][CLU_A_CSRC_BIT] && active_w[0] && !tick_w[0]) |=> $stable(stage_w[0]))
    else $error("filter moved without a table clock");
  dff_tick_a: assert property (@(posedge clk) disable iff (!reset_n)
    (seq_sel_reg == CLU_SEQ_DFLOP && active_w[0] && !tick_w[0]) |=> $stable(seq_q_reg))
    else $error("flip-flop moved off the even table clock");
  enable_off_a: assert property (@(posedge clk) disable iff (!reset_n)
    !glob_en_reg |=> table_result_event == 2'b00)
    else $error("output active while unit disabled");
endmodule

// ==== pkg/clu_pkg.sv ====
package clu_pkg;
  localparam int CLU_TABLES = 2;
  // Register offsets, byte addressed
  localparam logic [3:0] CLU_OFF_CTRL = 4'h0;
  localparam logic [3:0] CLU_OFF_SEQ = 4'h1;
  localparam logic [3:0] CLU_OFF_TBL = 4'h5;
  localparam logic [3:0] CLU_TBL_STRIDE = 4'h4;
  localparam logic [3:0] CLU_TBL_B = 4'h1;
  localparam logic [3:0] CLU_TBL_C = 4'h2;
  localparam logic [3:0] CLU_TBL_T = 4'h3;
  localparam logic [7:0] CLU_RESET_VAL = 8'h00;
  // Field positions
  localparam int CLU_CTRL_EN_BIT = 0;
  localparam int CLU_CTRL_RUN_BIT = 6;
  localparam int CLU_A_EDGE_BIT = 7;
  localparam int CLU_A_CSRC_BIT = 6;
  localparam int CLU_A_FILT_LSB = 4;
  localparam int CLU_A_PIN_BIT = 3;
  localparam int CLU_A_EN_BIT = 0;
  localparam int CLU_B_SRC1_LSB = 4;
  // Readable bit masks, reserved bits read zero
  localparam logic [7:0] CLU_CTRL_MASK = 8'h41;
  localparam logic [7:0] CLU_SEQ_MASK = 8'h0f;
  localparam logic [7:0] CLU_A_MASK = 8'hf9;
  localparam logic [7:0] CLU_C_MASK = 8'h0f;
  // Sequencer functions
  localparam logic [3:0] CLU_SEQ_OFF = 4'h0;
  localparam logic [3:0] CLU_SEQ_DFLOP = 4'h1;
  localparam logic [3:0] CLU_SEQ_TOGGLE = 4'h2;
  localparam logic [3:0] CLU_SEQ_LATCH = 4'h3;
  localparam logic [3:0] CLU_SEQ_SETCLR = 4'h4;
  // Output filter select
  localparam logic [1:0] CLU_FILT_NONE = 2'h0;
  localparam logic [1:0] CLU_FILT_SYNC = 2'h1;
  localparam logic [1:0] CLU_FILT_GLITCH = 2'h2;
  // Input source codes
  localparam logic [3:0] CLU_SRC_MASK = 4'h0;
  localparam logic [3:0] CLU_SRC_FEEDBACK = 4'h1;
  localparam logic [3:0] CLU_SRC_LINK = 4'h2;
  localparam logic [3:0] CLU_SRC_EVLINE0 = 4'h3;
  localparam logic [3:0] CLU_SRC_EVLINE1 = 4'h4;
  localparam logic [3:0] CLU_SRC_PIN = 4'h5;
  localparam logic [3:0] CLU_SRC_CMP = 4'h6;
  localparam logic [3:0] CLU_SRC_CAPT = 4'h7;
  localparam logic [3:0] CLU_SRC_MAIN = 4'h8;
  localparam logic [3:0] CLU_SRC_CTRLT = 4'h9;
  localparam logic [3:0] CLU_SRC_UART = 4'ha;
  localparam logic [3:0] CLU_SRC_SPI = 4'hb;

  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } clu_bus_req_type;

  // Peripheral sources, all on clk
  typedef struct packed {
    logic event_line_0;
    logic event_line_1;
    logic comparator_output;
    logic capture_timer_waveform;
    logic [2:0] main_timer_waveform;
    logic [1:0] control_timer_waveform;
    logic [1:0] serial_transceiver_line;
    logic [2:0] serial_peripheral_line;
  } clu_src_type;
endpackage

// ==== test/clu_src_model.sv ====
`timescale 1ns/1ns
module clu_src_model (
  input wire logic clk,
  input wire logic reset_n,
  input wire clu_pkg::clu_src_type src_want,
  input wire logic [5:0] pin_want,
  output clu_pkg::clu_src_type src,
  output logic [5:0] pin_in
);
  import clu_pkg::*;
  // On-chip sources launch their levels from clk, as the real peripherals do
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      src <= '0;
    end else begin
      // Serial lines carry whatever levels src_want gives, like every other source
      src <= src_want;
    end
  end
  // Pins are asynchronous, so they move half a cycle away from the sampling edge
  always_ff @(negedge clk) begin
    pin_in <= pin_want;
  end
endmodule

// ==== test/clu_core_tb_top.sv ====
`timescale 1ns/1ns
module clu_core_tb_top;
  import clu_pkg::*;
  logic clk;
  logic reset_n;
  clu_bus_req_type req;
  logic [7:0] bus_rdata;
  clu_src_type src_want;
  clu_src_type src;
  logic [5:0] pin_want;
  logic [5:0] pin_in;
  logic standby_sleep;
  logic idle_sleep;
  logic [1:0] table_result_event;
  logic [1:0] pin_out;
  logic [1:0] pin_oe;
  int err_count;
  int tests_run;
  int cycles;
  int lat [3];
  int i;

  clu_src_model u_clu_src_model (.clk(clk), .reset_n(reset_n), .src_want(src_want),
    .pin_want(pin_want), .src(src), .pin_in(pin_in));
  clu_core u_clu_core (.clk(clk), .reset_n(reset_n), .bus_req(req), .bus_rdata(bus_rdata),
    .src(src), .pin_in(pin_in), .standby_sleep(standby_sleep), .idle_sleep(idle_sleep),
    .table_result_event(table_result_event), .pin_out(pin_out), .pin_oe(pin_oe));

  // Free-running 10 MHz clock
  always #50 clk = ~clk;

  task automatic stop_test();
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // Hang guard, far above the few hundred cycles the sequence needs
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      err_count++;
      $display("MISMATCH t=%0t timeout", $time);
      stop_test();
    end
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t got %h expected %h", $time, got, exp);
    end
  endtask

  // Every bus task starts on a fresh edge, so no signal is assigned twice per step
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    req <= '0;
  endtask

  task automatic rd(input logic [3:0] a, input logic [7:0] exp);
    @(posedge clk);
    req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    req <= '0;
    #1;
    chk(bus_rdata, exp);
  endtask

  // Set the three source levels, wait n cycles, compare the masked outputs
  task automatic step(input logic e0, input logic e1, input logic c, input int n,
                      input logic [1:0] m, input logic [1:0] exp);
    @(posedge clk);
    src_want.event_line_0 <= e0;
    src_want.event_line_1 <= e1;
    src_want.comparator_output <= c;
    repeat (n) @(posedge clk);
    #1;
    chk({6'h00, table_result_event & m}, {6'h00, exp});
  endtask

  // Cycles from a rising event line to a rising table 0 output
  task automatic measure(output int n);
    @(posedge clk);
    src_want.event_line_0 <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      #1;
      n++;
    end while (table_result_event[0] !== 1'b1 && n < 20);
    @(posedge clk);
    src_want.event_line_0 <= 1'b0;
    repeat (10) @(posedge clk);
  endtask

  initial begin
    clk = 1'b0;
    reset_n = 1'b0;
    req = '0;
    src_want = '0;
    pin_want = 6'h00;
    standby_sleep = 1'b0;
    idle_sleep = 1'b0;
    err_count = 0;
    tests_run = 0;
    cycles = 0;
    repeat (12) @(posedge clk);
    reset_n <= 1'b1;
    // Whole map reads zero after reset, unmapped places too
    for (i = 0; i < 16; i++) begin
      rd(i[3:0], 8'h00);
    end
    wr(CLU_OFF_CTRL, 8'hff);
    rd(CLU_OFF_CTRL, 8'h41);
    wr(CLU_OFF_SEQ, 8'hff);
    rd(CLU_OFF_SEQ, 8'h0f);
    wr(CLU_OFF_SEQ, 8'h00);
    wr(CLU_OFF_CTRL, 8'h01);
    // Table 0: in0 event 0, in1 event 1, in2 comparator, truth 0x42, pin drive on
    wr(4'h6, 8'h43);
    wr(4'h7, 8'h06);
    wr(4'h8, 8'h42);
    wr(4'h5, 8'h09);
    rd(4'h5, 8'h09);
    for (i = 0; i < 8; i++) begin
      step(i[0], i[1], i[2], 5, 2'b01, {1'b0, 1'(8'h42 >> i)});
      chk({6'h00, pin_out}, {7'h00, 1'(8'h42 >> i)});
      chk({6'h00, pin_oe}, 8'h01);
    end
    // Sources back to idle so the latency runs start from a low input
    step(1'b0, 1'b0, 1'b0, 3, 2'b01, 2'b00);
    // Protected bytes refuse writes while enabled; clearing enable changes bit 0 only
    wr(4'h8, 8'hff);
    rd(4'h8, 8'h42);
    wr(4'h5, 8'h00);
    rd(4'h5, 8'h08);
    wr(4'h5, 8'h00);
    rd(4'h5, 8'h00);
    // Latency of plain, two-stage and glitch paths, relative to each other
    wr(4'h6, 8'h03);
    wr(4'h7, 8'h00);
    wr(4'h8, 8'h02);
    for (i = 0; i < 3; i++) begin
      wr(4'h5, {2'b00, i[1:0], 4'h1});
      measure(lat[i]);
      wr(4'h5, 8'h00);
    end
    chk(8'(lat[1] - lat[0]), 8'h02);
    chk(8'(lat[2] - lat[0]), 8'h04);
    // Two-cycle pulse must not get through the glitch filter
    wr(4'h5, 8'h21);
    step(1'b1, 1'b0, 1'b0, 1, 2'b01, 2'b00);
    step(1'b0, 1'b0, 1'b0, 8, 2'b01, 2'b00);
    // Standby: forced low without keep-running, alive with it
    step(1'b1, 1'b0, 1'b0, 10, 2'b01, 2'b01);
    @(posedge clk);
    standby_sleep <= 1'b1;
    step(1'b1, 1'b0, 1'b0, 3, 2'b01, 2'b00);
    wr(CLU_OFF_CTRL, 8'h41);
    step(1'b1, 1'b0, 1'b0, 10, 2'b01, 2'b01);
    @(posedge clk);
    standby_sleep <= 1'b0;
    wr(CLU_OFF_CTRL, 8'h01);
    wr(4'h5, 8'h00);
    wr(4'h5, 8'h01);
    // Idle sleep leaves the plain lookup running
    @(posedge clk);
    idle_sleep <= 1'b1;
    step(1'b0, 1'b0, 1'b0, 4, 2'b01, 2'b00);
    step(1'b1, 1'b0, 1'b0, 4, 2'b01, 2'b01);
    @(posedge clk);
    idle_sleep <= 1'b0;
    // Global enable low silences the outputs
    wr(CLU_OFF_CTRL, 8'h00);
    step(1'b1, 1'b0, 1'b0, 3, 2'b01, 2'b00);
    // Table 1 takes table 0 through the link input
    wr(4'ha, 8'h02);
    wr(4'hc, 8'h02);
    wr(4'h9, 8'h01);
    wr(CLU_OFF_CTRL, 8'h01);
    step(1'b1, 1'b0, 1'b0, 5, 2'b11, 2'b11);
    step(1'b0, 1'b0, 1'b0, 5, 2'b11, 2'b00);
    // Input 2 as clock reads low in the lookup; unit off while clock select changes
    wr(CLU_OFF_CTRL, 8'h00);
    wr(4'h5, 8'h00);
    wr(4'h9, 8'h00);
    wr(4'h7, 8'h06);
    wr(4'h8, 8'hf0);
    wr(4'h5, 8'h41);
    wr(CLU_OFF_CTRL, 8'h01);
    step(1'b0, 1'b0, 1'b1, 6, 2'b01, 2'b00);
    // Two-stage sync clocked by input 2: moves only on its rising edges
    wr(CLU_OFF_CTRL, 8'h00);
    wr(4'h5, 8'h00);
    wr(4'h8, 8'h02);
    wr(4'h5, 8'h51);
    wr(CLU_OFF_CTRL, 8'h01);
    step(1'b1, 1'b0, 1'b1, 6, 2'b01, 2'b00);
    step(1'b1, 1'b0, 1'b0, 3, 2'b01, 2'b00);
    step(1'b1, 1'b0, 1'b1, 3, 2'b01, 2'b00);
    step(1'b1, 1'b0, 1'b0, 3, 2'b01, 2'b00);
    step(1'b1, 1'b0, 1'b1, 4, 2'b01, 2'b01);
    wr(CLU_OFF_CTRL, 8'h00);
    wr(4'h5, 8'h00);
    wr(4'h7, 8'h00);
    wr(4'h8, 8'h02);
    // Pin input through the three-flop synchroniser
    wr(4'h6, 8'h05);
    wr(4'h5, 8'h01);
    wr(CLU_OFF_CTRL, 8'h01);
    @(posedge clk);
    pin_want <= 6'h01;
    step(1'b0, 1'b0, 1'b0, 8, 2'b01, 2'b01);
    @(posedge clk);
    pin_want <= 6'h00;
    step(1'b0, 1'b0, 1'b0, 8, 2'b01, 2'b00);
    wr(CLU_OFF_CTRL, 8'h00);
    wr(4'h5, 8'h00);
    wr(4'h6, 8'h03);
    // Set-clear latch: table 0 sets, table 1 clears
    wr(4'ha, 8'h04);
    wr(CLU_OFF_SEQ, 8'h04);
    wr(4'h5, 8'h01);
    wr(4'h9, 8'h01);
    wr(CLU_OFF_CTRL, 8'h01);
    step(1'b1, 1'b0, 1'b0, 2, 2'b01, 2'b01);
    step(1'b0, 1'b0, 1'b0, 5, 2'b01, 2'b01);
    step(1'b0, 1'b1, 1'b0, 2, 2'b01, 2'b00);
    step(1'b0, 1'b0, 1'b0, 5, 2'b01, 2'b00);
    // Data latch: table 1 is the gate, table 0 the data
    wr(4'h5, 8'h00);
    wr(4'h9, 8'h00);
    wr(CLU_OFF_SEQ, 8'h03);
    wr(4'h5, 8'h01);
    wr(4'h9, 8'h01);
    step(1'b1, 1'b1, 1'b0, 5, 2'b01, 2'b01);
    step(1'b1, 1'b0, 1'b0, 4, 2'b01, 2'b01);
    step(1'b0, 1'b0, 1'b0, 5, 2'b01, 2'b01);
    step(1'b0, 1'b1, 1'b0, 5, 2'b01, 2'b00);
    stop_test();
  end
endmodule
